/* File: hdl/acs_pkg.sv */
package acs_pkg;

  localparam int          ACS_DATA_W      = 32;
  localparam int          ACS_RES_W       = 10;
  localparam int          ACS_BUF_DEPTH   = 16;
  localparam int          ACS_CH_W        = 5;
  localparam int          ACS_NUM_CH      = 28;

  // Register byte addresses
  localparam logic [11:0] ACS_CTRL_ADDR   = 12'h000;
  localparam logic [11:0] ACS_CFG_ADDR    = 12'h004;
  localparam logic [11:0] ACS_SCAN_ADDR   = 12'h008;
  localparam logic [11:0] ACS_STAT_ADDR   = 12'h00c;
  localparam logic [11:0] ACS_BUF_ADDR    = 12'h040;
  localparam logic [11:0] ACS_BUF_MASK    = 12'hfc0;

  // Control register fields
  localparam int          CTL_DONE        = 0;
  localparam int          CTL_SAMPLE_ENABLE        = 1;
  localparam int          CTL_AUTO_SAMPLE_START        = 2;
  localparam int          CTL_STOP        = 4;
  localparam int          CTL_TRIG_LO     = 5;
  localparam int          CTL_ON          = 15;

  // Config register fields
  localparam int          CFG_CH_LO       = 0;
  localparam int          CFG_SCAN        = 8;
  localparam int          CFG_SMPI_LO     = 12;
  localparam int          CFG_SAMC_LO     = 16;

  localparam logic [2:0]  TRIG_MANUAL     = 3'h0;
  localparam logic [2:0]  TRIG_EXT        = 3'h1;
  localparam logic [2:0]  TRIG_AUTO       = 3'h7;

  localparam logic [7:0]  SAMC_RESET      = 8'h02;
  localparam logic [4:0]  SAR_BITS        = 5'h0a;

  // Least sample-plus-convert time for 1 Msps
  localparam int          MIN_PERIOD_NS   = 1000;
  localparam int          CLK_PERIOD_NS   = 100;
  localparam int          MIN_PERIOD_CYC  = MIN_PERIOD_NS / CLK_PERIOD_NS;

  typedef enum logic [3:0] {
    ACS_IDLE   = 4'b0001,
    ACS_SAMPLE = 4'b0010,
    ACS_CONV   = 4'b0100,
    ACS_STORE  = 4'b1000
  } acs_state_t;

  typedef struct packed {
    logic [ACS_CH_W-1:0] channel;
    logic                sampling;
    logic                converting;
  } acs_ana_ctl_t;

endpackage : acs_pkg

/* File: hdl/acs_sar.sv */
`timescale 1ns/100ps
module acs_sar
  import acs_pkg::*;
#(
  parameter int RES_W = ACS_RES_W
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             start,
  input  wire logic             abort,
  input  wire logic             comp_in,
  output logic [RES_W-1:0]      trial,
  output logic [RES_W-1:0]      result,
  output logic                  busy,
  output logic                  done
);

  logic [RES_W-1:0] sar_reg,  sar_next;
  logic [RES_W-1:0] bit_reg,  bit_next;
  logic             busy_reg, busy_next;
  logic             done_reg, done_next;

  assign trial  = sar_reg | bit_reg;
  assign result = sar_reg;
  assign busy   = busy_reg;
  assign done   = done_reg;

  // One bit per cycle, MSB first; comparator high keeps the trial bit
  always_comb begin
    sar_next  = sar_reg;
    bit_next  = bit_reg;
    busy_next = busy_reg;
    done_next = 1'b0;
    if (abort) begin
      busy_next = 1'b0;
      bit_next  = '0;
    end else if (start) begin
      sar_next  = '0;
      bit_next  = {1'b1, {(RES_W-1){1'b0}}};
      busy_next = 1'b1;
    end else if (busy_reg) begin
      if (comp_in) begin
        sar_next = sar_reg | bit_reg;
      end
      bit_next = bit_reg >> 1;
      if (bit_reg[0]) begin
        busy_next = 1'b0;
        done_next = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sar_reg  <= '0;
      bit_reg  <= '0;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      sar_reg  <= sar_next;
      bit_reg  <= bit_next;
      busy_reg <= busy_next;
      done_reg <= done_next;
    end
  end

endmodule : acs_sar

/* File: hdl/acs_seq.sv */
// How it works
// R1: stop bit halts at first irq, clears auto
// R2: stop bit clear: keep converting, overwrite buffer
// R3: auto bit restarts sampling after each conversion
// R4: auto clear: software write one starts sampling
// R5: manual trigger: writing zero starts conversion
// R6: other triggers: hardware clears sample bit
// R7: sample bit reads one while acquiring
// R8: done bit set when conversion completes
// R9: software clears done only, never sets
// R10: done clear leaves operation undisturbed
// R11: done cleared when new conversion begins
// R12: control bit three reads zero
// R13: software avoids access right after disable
// R14: sixteen word result buffer, selectable fill
// R15: ten-bit successive approximation result
// R16: channel select covers twenty-eight inputs
// R17: software selects conversion trigger source
// R18: sequencer runs regardless of cpu sleep
// R19: throughput up to one million samples/second; code takes at least 13 clocks per sample, 1.3 us at 100 ns
// R20: scan bits include or skip inputs
// R21: results stored in order, irq after count
// R22: disable aborts, keeps buffered results
//
// Implementation choices: register access over APB and the register addresses.
`timescale 1ns/100ps
module acs_seq
  import acs_pkg::*;
#(
  parameter int BUF_DEPTH = ACS_BUF_DEPTH,
  parameter int NUM_CH    = ACS_NUM_CH
) (
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [11:0]            paddr,
  input  wire logic [ACS_DATA_W-1:0]  pwdata,
  output logic      [ACS_DATA_W-1:0]  prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire logic                   ext_trigger,
  input  wire logic                   timer_trigger,
  input  wire logic                   comp_in,
  output acs_pkg::acs_ana_ctl_t       ana_ctl,
  output logic      [ACS_RES_W-1:0]   dac_code,
  output logic                        conv_irq
);
  import acs_pkg::*;

  localparam int IDX_W = $clog2(BUF_DEPTH);
  localparam int MIN_SAMC = (MIN_PERIOD_CYC > ACS_RES_W + 2) ? MIN_PERIOD_CYC - ACS_RES_W - 2 : 0;

  ////////////////////////////////////////////////////////////////////////
  // State
  acs_state_t             st_reg,    st_next;
  logic                   on_reg,    on_next;
  logic                   auto_sample_start_reg,  auto_sample_start_next;
  logic                   stop_reg,  stop_next;
  logic [2:0]             trig_reg,  trig_next;
  logic                   done_reg,  done_next;
  logic [ACS_CH_W-1:0]    chsel_reg, chsel_next;
  logic                   scan_reg,  scan_next;
  logic [3:0]             smpi_reg,  smpi_next;
  logic [7:0]             samc_reg,  samc_next;
  logic [31:0]            scan_input_select_reg,  scan_input_select_next;
  logic [ACS_CH_W-1:0]    ch_reg,    ch_next;
  logic [IDX_W-1:0]       wptr_reg,  wptr_next;
  logic [3:0]             cnt_reg,   cnt_next;
  logic [7:0]             stim_reg,  stim_next;
  logic                   irq_reg,   irq_next;
  logic                   ovw_reg,   ovw_next;
  logic [ACS_DATA_W-1:0]  rd_reg,    rd_next;
  logic [ACS_RES_W-1:0]   buf_mem [BUF_DEPTH];

  logic                   wr_acc, rd_acc;
  logic                   sar_start, sar_abort, sar_busy, sar_done;
  logic [ACS_RES_W-1:0]   sar_result;
  logic                   trig_hit;
  logic [ACS_CH_W-1:0]    scan_nxt_ch;
  logic [ACS_DATA_W-1:0]  ctrl_rd;

  assign wr_acc  = psel && penable && pwrite;
  assign rd_acc  = psel && !penable && !pwrite;
  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  assign prdata  = rd_reg;
  assign conv_irq = irq_reg;

  assign ana_ctl.channel    = ch_reg;
  assign ana_ctl.sampling   = (st_reg == ACS_SAMPLE);   // R7
  assign ana_ctl.converting = sar_busy;

  ////////////////////////////////////////////////////////////////////////
  // Converter core
  acs_sar #(.RES_W(ACS_RES_W)) u_sar (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (sar_start),
    .abort   (sar_abort),
    .comp_in (comp_in),
    .trial   (dac_code),
    .result  (sar_result),
    .busy    (sar_busy),
    .done    (sar_done)
  );

  // Next enabled scan input above the current one, wrapping to the lowest
  always_comb begin
    scan_nxt_ch = ch_reg;
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      if (scan_input_select_reg[i]) begin
        scan_nxt_ch = ACS_CH_W'(i);
      end
    end
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      if (scan_input_select_reg[i] && (ACS_CH_W'(i) > ch_reg)) begin
        scan_nxt_ch = ACS_CH_W'(i);
      end
    end
  end

  // R17
  always_comb begin
    case (trig_reg)
      TRIG_EXT:  trig_hit = ext_trigger;
      TRIG_AUTO: trig_hit = (stim_reg == 8'h00);
      default:   trig_hit = timer_trigger && (trig_reg != TRIG_MANUAL);
    endcase
  end

  always_comb begin
    ctrl_rd              = '0;                          // R12
    ctrl_rd[CTL_DONE]    = done_reg;
    ctrl_rd[CTL_SAMPLE_ENABLE]    = (st_reg == ACS_SAMPLE);      // R7
    ctrl_rd[CTL_AUTO_SAMPLE_START]    = auto_sample_start_reg;
    ctrl_rd[CTL_STOP]    = stop_reg;
    ctrl_rd[CTL_TRIG_LO +: 3] = trig_reg;
    ctrl_rd[CTL_ON]      = on_reg;
  end

  ////////////////////////////////////////////////////////////////////////
  // Sequencer and register file
  always_comb begin
    st_next    = st_reg;
    on_next    = on_reg;
    auto_sample_start_next  = auto_sample_start_reg;
    stop_next  = stop_reg;
    trig_next  = trig_reg;
    done_next  = done_reg;
    chsel_next = chsel_reg;
    scan_next  = scan_reg;
    smpi_next  = smpi_reg;
    samc_next  = samc_reg;
    scan_input_select_next  = scan_input_select_reg;
    ch_next    = ch_reg;
    wptr_next  = wptr_reg;
    cnt_next   = cnt_reg;
    stim_next  = (stim_reg != 8'h00) ? stim_reg - 8'h01 : stim_reg;
    irq_next   = 1'b0;
    ovw_next   = ovw_reg;
    rd_next    = rd_reg;
    sar_start  = 1'b0;
    sar_abort  = 1'b0;

    if (rd_acc) begin
      if (paddr == ACS_CTRL_ADDR) begin
        rd_next = ctrl_rd;
      end else if (paddr == ACS_CFG_ADDR) begin
        rd_next = {8'h00, samc_reg, smpi_reg, 3'h0, scan_reg, 3'h0, chsel_reg};
      end else if (paddr == ACS_SCAN_ADDR) begin
        rd_next = scan_input_select_reg;
      end else if (paddr == ACS_STAT_ADDR) begin
        rd_next = {16'h0000, 3'h0, ovw_reg, cnt_reg, 3'h0, ch_reg};
      end else if ((paddr & ACS_BUF_MASK) == ACS_BUF_ADDR) begin
        rd_next = {22'h000000, buf_mem[paddr[IDX_W+1:2]]};
      end else begin
        rd_next = '0;
      end
    end

    // Software writes; the sample bit write is acted on in the sequencer below
    if (wr_acc && paddr == ACS_CTRL_ADDR) begin
      on_next   = pwdata[CTL_ON];
      auto_sample_start_next = pwdata[CTL_AUTO_SAMPLE_START];
      stop_next = pwdata[CTL_STOP];
      trig_next = pwdata[CTL_TRIG_LO +: 3];
      if (!pwdata[CTL_DONE]) begin
        done_next = 1'b0;                               // R9 R10
      end
    end
    if (wr_acc && paddr == ACS_CFG_ADDR) begin
      chsel_next = pwdata[CFG_CH_LO +: ACS_CH_W];       // R16
      scan_next  = pwdata[CFG_SCAN];
      smpi_next  = pwdata[CFG_SMPI_LO +: 4];
      samc_next  = pwdata[CFG_SAMC_LO +: 8];
    end
    if (wr_acc && paddr == ACS_SCAN_ADDR) begin
      scan_input_select_next = pwdata;
    end

    case (st_reg)
      ACS_IDLE: begin
        if (on_next) begin
          if (auto_sample_start_reg || (wr_acc && paddr == ACS_CTRL_ADDR && pwdata[CTL_SAMPLE_ENABLE])) begin  // R3 R4
            st_next   = ACS_SAMPLE;
            stim_next = samc_reg;
            ch_next   = scan_reg ? (scan_input_select_reg[ch_reg] ? ch_reg : scan_nxt_ch) : chsel_reg;  // R20
          end
        end
      end
      ACS_SAMPLE: begin
        if ((trig_reg == TRIG_MANUAL && wr_acc && paddr == ACS_CTRL_ADDR && !pwdata[CTL_SAMPLE_ENABLE])  // R5
            || (trig_reg != TRIG_MANUAL && trig_hit)) begin                                   // R6
          st_next   = ACS_CONV;
          sar_start = 1'b1;                             // R15
          done_next = 1'b0;                             // R11
        end
      end
      ACS_CONV: begin
        if (sar_done) begin
          st_next = ACS_STORE;
        end
      end
      ACS_STORE: begin
        done_next = 1'b1;                               // R8
        wptr_next = wptr_reg + IDX_W'(1);               // R21
        if (scan_reg) begin
          ch_next = scan_nxt_ch;                        // R20
        end
        if (cnt_reg == smpi_reg) begin
          cnt_next  = '0;
          irq_next  = 1'b1;                             // R21
          wptr_next = '0;                               // R2
          ovw_next  = 1'b1;
          if (stop_reg) begin
            auto_sample_start_next = 1'b0;                           // R1
            st_next   = ACS_IDLE;
          end else begin
            st_next = ACS_IDLE;
          end
        end else begin
          cnt_next = cnt_reg + 4'h1;
          st_next  = ACS_IDLE;
        end
        if (auto_sample_start_next && on_reg) begin
          st_next   = ACS_SAMPLE;                       // R3 R19
          stim_next = (samc_reg > 8'(MIN_SAMC)) ? samc_reg : 8'(MIN_SAMC);
        end
      end
      default: st_next = ACS_IDLE;
    endcase

    // R22 R13
    if (!on_next) begin
      st_next   = ACS_IDLE;
      sar_abort = 1'b1;
      cnt_next  = '0;
      wptr_next = '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg    <= ACS_IDLE;
      on_reg    <= 1'b0;
      auto_sample_start_reg  <= 1'b0;
      stop_reg  <= 1'b0;
      trig_reg  <= TRIG_MANUAL;
      done_reg  <= 1'b0;
      chsel_reg <= '0;
      scan_reg  <= 1'b0;
      smpi_reg  <= '0;
      samc_reg  <= SAMC_RESET;
      scan_input_select_reg  <= '0;
      ch_reg    <= '0;
      wptr_reg  <= '0;
      cnt_reg   <= '0;
      stim_reg  <= '0;
      irq_reg   <= 1'b0;
      ovw_reg   <= 1'b0;
      rd_reg    <= '0;
    end else begin
      st_reg    <= st_next;
      on_reg    <= on_next;
      auto_sample_start_reg  <= auto_sample_start_next;
      stop_reg  <= stop_next;
      trig_reg  <= trig_next;
      done_reg  <= done_next;
      chsel_reg <= chsel_next;
      scan_reg  <= scan_next;
      smpi_reg  <= smpi_next;
      samc_reg  <= samc_next;
      scan_input_select_reg  <= scan_input_select_next;
      ch_reg    <= ch_next;
      wptr_reg  <= wptr_next;
      cnt_reg   <= cnt_next;
      stim_reg  <= stim_next;
      irq_reg   <= irq_next;
      ovw_reg   <= ovw_next;
      rd_reg    <= rd_next;
    end
  end

  // Result memory has no reset; disable leaves stored words untouched
  always_ff @(posedge pclk) begin
    if (st_reg == ACS_STORE) begin
      buf_mem[wptr_reg] <= sar_result;                  // R14
    end
  end

  // R18: no dependency on any cpu power state

endmodule : acs_seq

/* File: tb/acs_ana_model.sv */
`timescale 1ns/100ps
module acs_ana_model
  import acs_pkg::*;
(
  input  wire logic                   pclk,
  input  wire acs_pkg::acs_ana_ctl_t  ana_ctl,
  input  wire logic [ACS_RES_W-1:0]   dac_code,
  input  wire logic [ACS_RES_W-1:0]   level,
  output logic                        comp_in
);
  import acs_pkg::*;
  logic [ACS_RES_W-1:0] held = '0;
  logic                 tog  = 1'b0;
  // Tracks the input while acquiring, freezes while holding
  always @(posedge pclk) begin
    if (ana_ctl.sampling) begin
      held <= level;
    end
    tog <= ~tog;
  end
  // Outside conversion the comparator output is junk, so it toggles
  assign comp_in = ana_ctl.converting ? (held >= dac_code) : tog;
endmodule : acs_ana_model

/* File: tb/acs_seq_chk.sv */
`timescale 1ns/100ps
module acs_seq_chk
  import acs_pkg::*;
(
  input wire logic                  pclk,
  input wire logic                  presetn,
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pwrite,
  input wire logic [11:0]           paddr,
  input wire logic [ACS_DATA_W-1:0] pwdata,
  input wire logic                  pready,
  input wire logic                  pslverr,
  input wire acs_pkg::acs_ana_ctl_t ana_ctl,
  input wire logic                  conv_irq
);
  import acs_pkg::*;
  logic wr_ctl;
  assign wr_ctl = psel && penable && pwrite && paddr == ACS_CTRL_ADDR;
  // Mirrors the enable bit so a legal abort is not taken for a short conversion
  logic on_seen;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      on_seen <= 1'b0;
    end else if (wr_ctl) begin
      on_seen <= pwdata[CTL_ON];
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////
  a_ready_high: assert property (pready) else $error("pready low");
  a_no_slverr: assert property (!pslverr) else $error("slave error");
  a_irq_pulse: assert property (conv_irq |=> !conv_irq) else $error("irq too long");
  a_sample_enable_excl: assert property (!(ana_ctl.sampling && ana_ctl.converting))
    else $error("sampling while converting");
  a_conv_len: assert property ($rose(ana_ctl.converting) |->
    (ana_ctl.converting[*8] ##1 ana_ctl.converting ##1 ana_ctl.converting ##1 !ana_ctl.converting)
    or (##[1:10] !on_seen)) else $error("bad conversion length");
  a_off_idle: assert property (wr_ctl && !pwdata[CTL_ON] |->
    ##[1:2] !ana_ctl.sampling && !ana_ctl.converting) else $error("disable did not abort");
  a_manual_conv: assert property (wr_ctl && pwdata[CTL_ON] && !pwdata[CTL_SAMPLE_ENABLE] &&
    pwdata[7:5] == TRIG_MANUAL && ana_ctl.sampling |-> ##[1:2] ana_ctl.converting)
    else $error("no conversion after sample end");
  a_sample_enable_start: assert property (wr_ctl && pwdata[CTL_ON] && pwdata[CTL_SAMPLE_ENABLE] &&
    !ana_ctl.sampling && !ana_ctl.converting |-> ##[1:2] ana_ctl.sampling)
    else $error("sampling did not start");
endmodule : acs_seq_chk

bind acs_seq acs_seq_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .pready, .pslverr, .ana_ctl, .conv_irq);

/* File: tb/adc_sample_convert_sequencer_test.sv */
`timescale 1ns/100ps
module adc_sample_convert_sequencer_test;
  import acs_pkg::*;
  logic                  pclk          = 1'b0;
  logic                  presetn       = 1'b0;
  logic                  psel          = 1'b0;
  logic                  penable       = 1'b0;
  logic                  pwrite        = 1'b0;
  logic [11:0]           paddr         = 12'h000;
  logic [ACS_DATA_W-1:0] pwdata        = 32'h0;
  logic [ACS_DATA_W-1:0] prdata;
  logic [ACS_DATA_W-1:0] rd;
  logic                  pready;
  logic                  pslverr;
  logic                  ext_trigger   = 1'b0;
  logic                  timer_trigger = 1'b0;
  logic                  comp_in;
  logic [ACS_RES_W-1:0]  dac_code;
  logic [ACS_RES_W-1:0]  level         = 10'h000;
  logic                  conv_irq;
  acs_ana_ctl_t          ana_ctl;
  int                    err_total     = 0;
  int                    compares      = 0;

  acs_seq DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .ext_trigger, .timer_trigger, .comp_in, .ana_ctl, .dac_code, .conv_irq);
  acs_ana_model u_ana (.pclk, .ana_ctl, .dac_code, .level, .comp_in);

  initial begin
    forever #50 pclk = ~pclk;
  end
  ////////////////////////////////////////
  task automatic give_verdict();
    if (err_total == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : give_verdict

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  // Starts one edge late so a new setup never lands in the release time step
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      n++;
      if (n > 20) begin
        err_total++;
        give_verdict();
      end
      @(posedge pclk);
    end
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rd, exp);
  endtask : rdchk

  // Mode 0 waits for the interrupt pulse, mode 1 for a conversion, mode 2 for sampling
  task automatic wait_on(input int m);
    int n;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
      if (n > 2000) begin
        err_total++;
        give_verdict();
      end
    end while (!(m == 0 ? conv_irq === 1'b1 : m == 1 ? ana_ctl.converting === 1'b1 : ana_ctl.sampling === 1'b1));
  endtask : wait_on
  ////////////////////////////////////////
  task automatic t_reset_map();
    rdchk(ACS_CTRL_ADDR, 32'h0);
    rdchk(ACS_CFG_ADDR, 32'h0002_0000);
    apb(1'b1, ACS_SCAN_ADDR, 32'h0fff_ffff);
    rdchk(ACS_SCAN_ADDR, 32'h0fff_ffff);
    apb(1'b1, 12'h020, 32'hffff_ffff);
    rdchk(12'h020, 32'h0);
  endtask : t_reset_map

  task automatic t_manual();
    level <= 10'h2a5;
    apb(1'b1, ACS_CTRL_ADDR, 32'h0000_800a);
    rdchk(ACS_CTRL_ADDR, 32'h0000_8002);
    apb(1'b1, ACS_CTRL_ADDR, 32'h0000_8000);
    wait_on(0);
    rdchk(ACS_CTRL_ADDR, 32'h0000_8001);
    rdchk(ACS_BUF_ADDR, 32'h0000_02a5);
    level <= 10'h15a;
    apb(1'b1, ACS_CTRL_ADDR, 32'h0000_8002);
    apb(1'b1, ACS_CTRL_ADDR, 32'h0000_8000);
    rdchk(ACS_CTRL_ADDR, 32'h0000_8000);
    apb(1'b1, ACS_CTRL_ADDR, 32'h0000_8000);
    wait_on(0);
    rdchk(ACS_BUF_ADDR, 32'h0000_015a);
    apb(1'b1, ACS_CTRL_ADDR, 32'h0000_8002);
    apb(1'b1, ACS_CTRL_ADDR, 32'h0000_0000);
    repeat (2) @(posedge pclk);
    check({31'h0, ana_ctl.sampling}, 32'h0);
    rdchk(ACS_BUF_ADDR, 32'h0000_015a);
  endtask : t_manual

  task automatic t_triggers();
    for (int i = 0; i < 2; i++) begin
      level <= 10'h0c3 + 10'(i);
      apb(1'b1, ACS_CTRL_ADDR, 32'h0000_8002 | (32'(i + 1) << CTL_TRIG_LO));
      ext_trigger <= (i == 0);
      timer_trigger <= (i == 1);
      wait_on(1);
      ext_trigger <= 1'b0;
      timer_trigger <= 1'b0;
      apb(1'b0, ACS_CTRL_ADDR, 32'h0);
      check(rd & 32'h3, 32'h0);
      wait_on(0);
      rdchk(ACS_BUF_ADDR, 32'(10'h0c3 + 10'(i)));
    end
  endtask : t_triggers

  task automatic t_auto();
    apb(1'b1, ACS_CTRL_ADDR, 32'h0000_0000);
    apb(1'b1, ACS_CFG_ADDR, 32'h0002_1000);
    level <= 10'h3ff;
    apb(1'b1, ACS_CTRL_ADDR, 32'h0000_80f4);
    wait_on(0);
    rdchk(ACS_CTRL_ADDR, 32'h0000_80f1);
    rdchk(ACS_BUF_ADDR, 32'h0000_03ff);
    rdchk(ACS_BUF_ADDR + 12'h004, 32'h0000_03ff);
    repeat (30) @(posedge pclk);
    check({31'h0, ana_ctl.converting}, 32'h0);
    apb(1'b1, ACS_CFG_ADDR, 32'h0002_0000);
    apb(1'b1, ACS_CTRL_ADDR, 32'h0000_80e4);
    wait_on(0);
    wait_on(0);
    wait_on(1);
    apb(1'b0, ACS_CTRL_ADDR, 32'h0);
    check(rd & 32'h4, 32'h4);
    check(rd & 32'h1, 32'h0);
    apb(1'b1, ACS_CTRL_ADDR, 32'h0000_0000);
  endtask : t_auto

  task automatic t_scan();
    apb(1'b1, ACS_SCAN_ADDR, 32'h0000_0024);
    apb(1'b1, ACS_CFG_ADDR, 32'h0002_1100);
    apb(1'b1, ACS_CTRL_ADDR, 32'h0000_80f4);
    repeat (2) @(posedge pclk);
    check({27'h0, ana_ctl.channel}, 32'h2);
    wait_on(1);
    wait_on(2);
    check({27'h0, ana_ctl.channel}, 32'h5);
    wait_on(0);
    rdchk(ACS_STAT_ADDR, 32'h0000_1002);
    apb(1'b1, ACS_CTRL_ADDR, 32'h0000_0000);
  endtask : t_scan

  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_reset_map();
    t_manual();
    t_triggers();
    t_auto();
    t_scan();
    give_verdict();
  end
endmodule : adc_sample_convert_sequencer_test
